// ### bench/alusd_datapath_bench.sv
`timescale 1ns/100ps
`include "alusd_map.vh"
module alusd_datapath_bench;
  reg clk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg ce_in = 1'b1;
  reg [3:0] op = 4'h0;
  reg [4:0] fa = 5'h00;
  reg [7:0] lit = 8'h00;
  reg ul = 1'b0;
  reg df = 1'b0;
  reg clr = 1'b0;
  reg slp = 1'b0;
  reg wto = 1'b0;
  reg wake = 1'b0;
  wire [11:0] pw;
  wire pv;
  wire [9:0] pa;
  wire [7:0] acc;
  wire [7:0] st;
  wire [7:0] frd;
  integer fail_count = 0;
  integer check_count = 0;
  // Clock at 100 MHz.
  always #5 clk_in = ~clk_in;
  alusd_prog_model prog_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(pa),
    .word_out(pw), .valid_out(pv));
  // Branch and its target are tied; bit ops always work on bit 5, the page bit.
  alusd_datapath dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .prog_word_in(pw), .prog_valid_in(pv), .op_in(op), .file_addr_in(fa), .literal_in(lit),
    .use_literal_in(ul), .dest_file_in(df), .bit_sel_in(3'h5), .branch_in(1'b0),
    .branch_target_in(10'h000), .watchdog_clear_op_in(clr), .sleep_op_in(slp),
    .watchdog_timeout_in(wto), .pin_wake_in(wake), .instr_word_out(), .prog_addr_out(pa),
    .acc_out(acc), .status_out(st), .fsr_out(), .file_rdata_out(frd), .exec_valid_out(),
    .stall_out());
  task chk8(input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One op for one cycle; its result is on the outputs two edges after it is taken.
  task run_op(input [3:0] o, input [4:0] a, input [7:0] l, input u, input d);
    @(posedge clk_in);
    op <= o;
    fa <= a;
    lit <= l;
    ul <= u;
    df <= d;
    @(posedge clk_in);
    op <= `ALUSD_OP_NOP;
    df <= 1'b0;
    ul <= 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
  endtask
  // Pulse form for the watchdog and sleep events, same latency as an op.
  task pulse(input c, input s, input t, input w);
    @(posedge clk_in);
    clr <= c;
    slp <= s;
    wto <= t;
    wake <= w;
    @(posedge clk_in);
    clr <= 1'b0;
    slp <= 1'b0;
    wto <= 1'b0;
    wake <= 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
  endtask
  task s_reset;
    chk8(st, 8'h18);
    chk8(acc, 8'h00);
  endtask
  // Low-nibble carry, then a wrap to zero with carry out.
  task s_arith;
    run_op(`ALUSD_OP_MOV, 5'h00, 8'h0F, 1'b1, 1'b0);
    chk8(acc, 8'h0F);
    run_op(`ALUSD_OP_ADD, 5'h00, 8'h01, 1'b1, 1'b0);
    chk8(acc, 8'h10);
    chk8(st, 8'h1A);
    run_op(`ALUSD_OP_ADD, 5'h00, 8'hF0, 1'b1, 1'b0);
    chk8(acc, 8'h00);
    chk8(st, 8'h1D);
  endtask
  // Borrow and no borrow, then a file store and a read back through the unit.
  task s_sub_file;
    run_op(`ALUSD_OP_MOV, 5'h00, 8'h05, 1'b1, 1'b0);
    run_op(`ALUSD_OP_SUB, 5'h00, 8'h03, 1'b1, 1'b0);
    chk8(acc, 8'hFE);
    chk8(st, 8'h18);
    run_op(`ALUSD_OP_SUB, 5'h00, 8'hFE, 1'b1, 1'b0);
    chk8(acc, 8'h00);
    chk8(st, 8'h1F);
    run_op(`ALUSD_OP_MOV, 5'h00, 8'h5A, 1'b1, 1'b0);
    run_op(`ALUSD_OP_MOV, 5'h08, 8'h00, 1'b0, 1'b1);
    chk8(st, 8'h1B);
    run_op(`ALUSD_OP_COM, 5'h08, 8'h00, 1'b0, 1'b0);
    chk8(acc, 8'hA5);
    chk8(frd, 8'h5A);
  endtask
  // An op offered while the enable is low must leave no trace.
  task s_hold;
    @(posedge clk_in);
    ce_in <= 1'b0;
    run_op(`ALUSD_OP_ADD, 5'h00, 8'h01, 1'b1, 1'b0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk8(acc, 8'hA5);
    chk8(st, 8'h1B);
  endtask
  // A move keeps flags as written, but time-out, sleep and bit 6 stay put.
  task s_status_dest;
    run_op(`ALUSD_OP_MOV, 5'h00, 8'hFF, 1'b1, 1'b0);
    run_op(`ALUSD_OP_MOV, 5'h03, 8'h00, 1'b0, 1'b1);
    chk8(st, 8'hBF);
    run_op(`ALUSD_OP_CLR, 5'h03, 8'h00, 1'b0, 1'b1);
    chk8(st, 8'h1F);
    run_op(`ALUSD_OP_BSF, 5'h03, 8'h00, 1'b0, 1'b1);
    chk8(st, 8'h3F);
    run_op(`ALUSD_OP_BCF, 5'h03, 8'h00, 1'b0, 1'b1);
    chk8(st, 8'h1F);
  endtask
  task s_watchdog;
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    chk8(st, 8'h0F);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk8(st, 8'h1F);
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    chk8(st, 8'h17);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    chk8(st, 8'h97);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // The fetch side needs two edges before the first word counts as valid.
    repeat (2) @(posedge clk_in);
    #1;
    s_reset;
    s_arith;
    s_sub_file;
    s_hold;
    s_status_dest;
    s_watchdog;
    give_verdict;
  end
endmodule // alusd_datapath_bench

// ### bench/alusd_dp_properties.sv
`timescale 1ns/100ps
`include "alusd_map.vh"
// Watches the datapath ports; results show two edges after the op is taken.
module alusd_dp_properties #(
  parameter AW = 5
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire ce_in,
  input wire prog_valid_in,
  input wire [3:0] op_in,
  input wire [AW-1:0] file_addr_in,
  input wire [7:0] literal_in,
  input wire use_literal_in,
  input wire dest_file_in,
  input wire watchdog_clear_op_in,
  input wire sleep_op_in,
  input wire watchdog_timeout_in,
  input wire [7:0] acc_out,
  input wire [7:0] status_out,
  input wire stall_out
);
  reg pv_q;
  wire ex;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // An op only runs when the word was valid one edge earlier and no flush is on.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pv_q <= 1'b0;
    end else begin
      pv_q <= prog_valid_in;
    end
  end
  assign ex = ce_in && !stall_out && pv_q;
  property p_gap; status_out[6] == 1'b0; endproperty
  a_gap: assert property (p_gap) else $error("status bit 6 set");
  property p_to_set;
    ce_in && (watchdog_clear_op_in || sleep_op_in) && !watchdog_timeout_in |=> ##1 status_out[4];
  endproperty
  a_to_set: assert property (p_to_set) else $error("time-out flag not set");
  property p_to_clr; ce_in && watchdog_timeout_in |=> ##1 !status_out[4]; endproperty
  a_to_clr: assert property (p_to_clr) else $error("time-out flag not cleared");
  property p_to_only;
    $changed(status_out[4]) |-> $past(watchdog_clear_op_in || sleep_op_in || watchdog_timeout_in, 2);
  endproperty
  a_to_only: assert property (p_to_only) else $error("time-out flag moved by a write");
  property p_pd_only;
    $changed(status_out[3]) |-> $past(watchdog_clear_op_in || sleep_op_in, 2);
  endproperty
  a_pd_only: assert property (p_pd_only) else $error("sleep flag moved by a write");
  property p_clr;
    ex && op_in == `ALUSD_OP_CLR && dest_file_in && !use_literal_in && file_addr_in == 5'h03
      |=> ##1 status_out[7:5] == 3'b000 && status_out[2] &&
      status_out[1:0] == $past(status_out[1:0]);
  endproperty
  a_clr: assert property (p_clr) else $error("status clear wrong");
  property p_keep;
    ex && op_in == `ALUSD_OP_MOV && dest_file_in && !use_literal_in && file_addr_in != 5'h03
      |=> ##1 status_out[2:0] == $past(status_out[2:0]);
  endproperty
  a_keep: assert property (p_keep) else $error("move to file changed a flag");
  property p_zero;
    ex && op_in == `ALUSD_OP_ADD && use_literal_in |=> ##1 status_out[2] == (acc_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_mov;
    ex && op_in == `ALUSD_OP_MOV && use_literal_in |=> ##1 acc_out == $past(literal_in, 2);
  endproperty
  a_mov: assert property (p_mov) else $error("literal load wrong");
endmodule // alusd_dp_properties
bind alusd_datapath alusd_dp_properties #(.AW(AW)) chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .ce_in(ce_in), .prog_valid_in(prog_valid_in), .op_in(op_in), .file_addr_in(file_addr_in),
  .literal_in(literal_in), .use_literal_in(use_literal_in), .dest_file_in(dest_file_in),
  .watchdog_clear_op_in(watchdog_clear_op_in), .sleep_op_in(sleep_op_in),
  .watchdog_timeout_in(watchdog_timeout_in), .acc_out(acc_out), .status_out(status_out),
  .stall_out(stall_out));

// ### bench/alusd_prog_model.sv
`timescale 1ns/100ps
// Program store beside the core; a whole word comes back on its own bus each cycle.
module alusd_prog_model #(
  parameter PCW = 10
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire [PCW-1:0] addr_in,
  output reg [11:0] word_out,
  output reg valid_out
);
  // The word is a scramble of the address, so a stale fetch shows up as a new pattern.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_out <= 12'h000;
      valid_out <= 1'b0;
    end else begin
      word_out <= {2'b00, addr_in} ^ 12'hA5A;
      valid_out <= 1'b1;
    end
  end
endmodule // alusd_prog_model

// ### logic/alusd_alu.v
`timescale 1ns/100ps
`include "alusd_map.vh"
// Combinational eight-bit arithmetic unit with flag outputs.
module alusd_alu (
  input wire [3:0] op_in,
  input wire [7:0] acc_in,
  input wire [7:0] opnd_in,
  input wire [2:0] bit_in,
  input wire carry_in,
  output reg [7:0] result_out,
  output reg c_out,
  output reg dc_out,
  output reg z_out,
  output reg c_upd_out,
  output reg dc_upd_out,
  output reg z_upd_out
);
  reg [8:0] sum;
  reg [4:0] nib;

  // Subtract is opnd plus inverted acc plus one, so carry set means no borrow.
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    result_out = opnd_in;
    c_out = carry_in;
    dc_out = 1'b0;
    c_upd_out = 1'b0;
    dc_upd_out = 1'b0;
    z_upd_out = 1'b0;
    case (op_in)
      `ALUSD_OP_ADD: begin
        sum = {1'b0, opnd_in} + {1'b0, acc_in};
        nib = {1'b0, opnd_in[3:0]} + {1'b0, acc_in[3:0]};
        result_out = sum[7:0];
        c_out = sum[8];
        dc_out = nib[4];
        {c_upd_out, dc_upd_out, z_upd_out} = 3'b111;
      end
      `ALUSD_OP_SUB: begin
        sum = {1'b0, opnd_in} + {1'b0, ~acc_in} + 9'h001;
        nib = {1'b0, opnd_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
        result_out = sum[7:0];
        c_out = sum[8];
        dc_out = nib[4];
        {c_upd_out, dc_upd_out, z_upd_out} = 3'b111;
      end
      `ALUSD_OP_AND: begin
        result_out = opnd_in & acc_in;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_IOR: begin
        result_out = opnd_in | acc_in;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_XOR: begin
        result_out = opnd_in ^ acc_in;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_COM: begin
        result_out = ~opnd_in;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_INC: begin
        result_out = opnd_in + 8'h01;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_DEC: begin
        result_out = opnd_in - 8'h01;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_RLF: begin
        result_out = {opnd_in[6:0], carry_in};
        c_out = opnd_in[7];
        c_upd_out = 1'b1;
      end
      `ALUSD_OP_RRF: begin
        result_out = {carry_in, opnd_in[7:1]};
        c_out = opnd_in[0];
        c_upd_out = 1'b1;
      end
      `ALUSD_OP_SWAP: result_out = {opnd_in[3:0], opnd_in[7:4]};
      `ALUSD_OP_MOV: begin
        result_out = opnd_in;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_CLR: begin
        result_out = 8'h00;
        z_upd_out = 1'b1;
      end
      `ALUSD_OP_BCF: result_out = opnd_in & ~(8'h01 << bit_in);
      `ALUSD_OP_BSF: result_out = opnd_in | (8'h01 << bit_in);
      default: result_out = opnd_in;
    endcase
    z_out = (result_out == 8'h00);
  end
endmodule // alusd_alu

// ### logic/alusd_datapath.v
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "alusd_map.vh"
// Accumulator, status register and file datapath of the core.
// Program words arrive on their own bus, data on another.
module alusd_datapath #(
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter PCW = 10
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire ce_in,
  input wire [11:0] prog_word_in,
  input wire prog_valid_in,
  input wire [3:0] op_in,
  input wire [AW-1:0] file_addr_in,
  input wire [7:0] literal_in,
  input wire use_literal_in,
  input wire dest_file_in,
  input wire [2:0] bit_sel_in,
  input wire branch_in,
  input wire [PCW-1:0] branch_target_in,
  input wire watchdog_clear_op_in,
  input wire sleep_op_in,
  input wire watchdog_timeout_in,
  input wire pin_wake_in,
  output reg [11:0] instr_word_out,
  output reg [PCW-1:0] prog_addr_out,
  output reg [7:0] acc_out,
  output reg [7:0] status_out,
  output reg [7:0] fsr_out,
  output reg [7:0] file_rdata_out,
  output reg exec_valid_out,
  output wire stall_out
);
  reg [7:0] acc_q;
  reg [7:0] status_q;
  reg [7:0] fsr_q;
  reg [PCW-1:0] pc_q;
  reg [11:0] ir_q;
  reg ir_valid_q;
  reg flush_q;
  wire [7:0] mem_rdata;
  wire [AW-1:0] eff_addr;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire upd_c;
  wire upd_dc;
  wire upd_z;
  reg [7:0] file_val;
  reg [7:0] opnd;
  reg [7:0] status_d;
  reg mem_we;
  reg [7:0] ra_hold_q;

  // Indirect access through the pointer register reaches every location.
  function [AW-1:0] resolve;
    input [AW-1:0] a;
    input [7:0] ptr;
    begin
      resolve = (a == `ALUSD_ADDR_INDF) ? ptr[AW-1:0] : a;
    end
  endfunction

  assign eff_addr = resolve(file_addr_in, fsr_q);

  // A move to a file stores the accumulator and leaves every flag alone, except a move to the status register.
  wire move_wf = (op_in == `ALUSD_OP_MOV) & dest_file_in & ~use_literal_in;

  // Store read data are registered in the store and again in ra_hold_q, so they come two edges late.
  alusd_regfile #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .we_in(mem_we),
    .waddr_in(eff_addr),
    .wdata_in(alu_result),
    .raddr_in(eff_addr),
    .rdata_out(mem_rdata)
  );

  // Special registers sit in the same data map as general ones.
  always @* begin
    case (eff_addr)
      `ALUSD_ADDR_PCL: file_val = pc_q[7:0];
      `ALUSD_ADDR_STATUS: file_val = status_q;
      `ALUSD_ADDR_FSR: file_val = fsr_q;
      default: file_val = ra_hold_q;
    endcase
    opnd = use_literal_in ? literal_in : (move_wf ? acc_q : file_val);
  end

  alusd_alu u_alu (
    .op_in(op_in),
    .acc_in(acc_q),
    .opnd_in(opnd),
    .bit_in(bit_sel_in),
    .carry_in(status_q[`ALUSD_BIT_C]),
    .result_out(alu_result),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .c_upd_out(upd_c),
    .dc_upd_out(upd_dc),
    .z_upd_out(upd_z)
  );

  wire exec = ce_in & ir_valid_q & ~flush_q & (op_in != `ALUSD_OP_NOP);
  wire to_file = exec & dest_file_in & ~use_literal_in;
  wire st_dest = to_file & (eff_addr == `ALUSD_ADDR_STATUS);
  // The zero flag follows the unit except on a move to a file.
  wire z_flag_upd = upd_z & ~move_wf;

  always @* begin
    mem_we = to_file & (eff_addr > `ALUSD_ADDR_FSR);
  end

  // Status next value: written bits first, then flag logic and reset cause.
  always @* begin
    status_d = status_q;
    if (st_dest) begin
      // Protected time-out and sleep bits keep their value.
      status_d = (alu_result & `ALUSD_STATUS_WMASK) |
                 (status_q & ~`ALUSD_STATUS_WMASK);
      status_d[6] = 1'b0;
      // Flags the instruction affects come from flag logic, not the result.
      if (upd_c) status_d[`ALUSD_BIT_C] = status_q[`ALUSD_BIT_C];
      if (upd_dc) status_d[`ALUSD_BIT_DC] = status_q[`ALUSD_BIT_DC];
      if (z_flag_upd) status_d[`ALUSD_BIT_Z] = status_q[`ALUSD_BIT_Z];
      // Clearing the status register keeps carry and half-carry as they were.
      if (op_in == `ALUSD_OP_CLR) begin
        status_d[`ALUSD_BIT_C] = status_q[`ALUSD_BIT_C];
        status_d[`ALUSD_BIT_DC] = status_q[`ALUSD_BIT_DC];
      end
    end
    if (exec) begin
      if (upd_c) status_d[`ALUSD_BIT_C] = alu_c;
      if (upd_dc) status_d[`ALUSD_BIT_DC] = alu_dc;
      if (z_flag_upd) status_d[`ALUSD_BIT_Z] = alu_z;
    end
    if (ce_in & watchdog_clear_op_in) begin
      status_d[`ALUSD_BIT_TO] = 1'b1;
      status_d[`ALUSD_BIT_PD] = 1'b1;
    end
    if (ce_in & sleep_op_in) begin
      status_d[`ALUSD_BIT_TO] = 1'b1;
      status_d[`ALUSD_BIT_PD] = 1'b0;
    end
    // A time-out in the same cycle as a clear wins, so it is never lost.
    if (ce_in & watchdog_timeout_in) status_d[`ALUSD_BIT_TO] = 1'b0;
    if (ce_in & pin_wake_in) status_d[`ALUSD_BIT_WAKE] = 1'b1;
  end

  // Status, accumulator and pointer registers; power-up sets time-out.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= `ALUSD_STATUS_RST;
      acc_q <= 8'h00;
      fsr_q <= 8'h00;
      ra_hold_q <= 8'h00;
    end else if (ce_in) begin
      status_q <= status_d;
      ra_hold_q <= mem_rdata;
      if (exec & (~dest_file_in | use_literal_in) & (op_in != `ALUSD_OP_BCF) &
          (op_in != `ALUSD_OP_BSF)) begin
        acc_q <= alu_result;
      end
      if (to_file & (eff_addr == `ALUSD_ADDR_FSR)) begin
        fsr_q <= alu_result;
      end
    end
  end

  // Fetch and execute overlap; a taken branch flushes the fetched word.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q <= {PCW{1'b0}};
      ir_q <= 12'h000;
      ir_valid_q <= 1'b0;
      flush_q <= 1'b0;
    end else if (ce_in) begin
      ir_q <= prog_word_in;
      ir_valid_q <= prog_valid_in;
      flush_q <= branch_in & ir_valid_q;
      if (branch_in & ir_valid_q & ~flush_q) begin
        pc_q <= {status_q[`ALUSD_BIT_PA], branch_target_in[PCW-2:0]};
      end else if (to_file & (eff_addr == `ALUSD_ADDR_PCL)) begin
        pc_q <= {status_q[`ALUSD_BIT_PA], 1'b0, alu_result};
      end else begin
        pc_q <= pc_q + {{(PCW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign stall_out = flush_q;

  // Outputs registered from state.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      instr_word_out <= 12'h000;
      prog_addr_out <= {PCW{1'b0}};
      acc_out <= 8'h00;
      status_out <= `ALUSD_STATUS_RST;
      fsr_out <= 8'h00;
      file_rdata_out <= 8'h00;
      exec_valid_out <= 1'b0;
    end else if (ce_in) begin
      instr_word_out <= ir_q;
      prog_addr_out <= pc_q;
      acc_out <= acc_q;
      status_out <= status_q;
      fsr_out <= fsr_q;
      file_rdata_out <= file_val;
      exec_valid_out <= exec;
    end
  end
endmodule // alusd_datapath

// ### logic/alusd_map.vh
`ifndef ALUSD_MAP_VH
`define ALUSD_MAP_VH
`define ALUSD_ADDR_INDF 5'h00
`define ALUSD_ADDR_PCL 5'h02
`define ALUSD_ADDR_STATUS 5'h03
`define ALUSD_ADDR_FSR 5'h04
`define ALUSD_BIT_C 0
`define ALUSD_BIT_DC 1
`define ALUSD_BIT_Z 2
`define ALUSD_BIT_PD 3
`define ALUSD_BIT_TO 4
`define ALUSD_BIT_PA 5
`define ALUSD_BIT_WAKE 7
`define ALUSD_STATUS_RST 8'h18
`define ALUSD_STATUS_WMASK 8'hA7
// Operation codes on the decoder port.
`define ALUSD_OP_NOP 4'h0
`define ALUSD_OP_ADD 4'h1
`define ALUSD_OP_SUB 4'h2
`define ALUSD_OP_AND 4'h3
`define ALUSD_OP_IOR 4'h4
`define ALUSD_OP_XOR 4'h5
`define ALUSD_OP_COM 4'h6
`define ALUSD_OP_INC 4'h7
`define ALUSD_OP_DEC 4'h8
`define ALUSD_OP_RLF 4'h9
`define ALUSD_OP_RRF 4'hA
`define ALUSD_OP_SWAP 4'hB
`define ALUSD_OP_MOV 4'hC
`define ALUSD_OP_CLR 4'hD
`define ALUSD_OP_BCF 4'hE
`define ALUSD_OP_BSF 4'hF
`endif

// ### logic/alusd_regfile.v
`timescale 1ns/100ps
// Small general-purpose data store; read data come out of a register.
module alusd_regfile #(
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_in,
  input wire ce_in,
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [7:0] wdata_in,
  input wire [AW-1:0] raddr_in,
  output reg [7:0] rdata_out
);
  reg [7:0] mem_q [0:DEPTH-1];

  // No reset on the array keeps it a plain memory; read is registered.
  always @(posedge clk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule // alusd_regfile
